// File: fpc_cfg.svh
// Constants of the front-panel control block: offsets, fields, reset values
`ifndef FPC_CFG_SVH
`define FPC_CFG_SVH

// ----------------------------------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------------------------------
`define FPC_OFS_CTRL 12'h000
`define FPC_OFS_STATUS 12'h004
`define FPC_OFS_SWITCH 12'h008
`define FPC_OFS_LAMPS 12'h00C

// ----------------------------------------------------------------
// Fields and reset values
// ----------------------------------------------------------------
`define FPC_CTRL_BTN_EN 0
`define FPC_CTRL_RESET 32'h0000_0001
`define FPC_HALT_CODE 8'hFF
`define FPC_ST_STOP 0
`define FPC_ST_RUN 1
`define FPC_ST_INT 2
`define FPC_ST_PEND 3
`define FPC_ST_STEP 4

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define FPC_CLK_MHZ 250
`define FPC_DEBOUNCE_MS 5
`define FPC_DEBOUNCE_CYC (`FPC_DEBOUNCE_MS * 1000 * `FPC_CLK_MHZ)

`endif

// File: fpc_pkg.sv
// Types shared by the front-panel control block
package fpc_pkg;

  // Operating mode of the panel sequencer
  typedef enum logic [1:0] {
    FPC_MODE_STOP = 2'b00,
    FPC_MODE_RUN = 2'b01,
    FPC_MODE_STEP = 2'b10
  } fpc_mode_e;

  // Machine cycle kind reported by the core
  typedef enum logic [1:0] {
    FPC_CYC_FIRST = 2'b00,
    FPC_CYC_LATER = 2'b01,
    FPC_CYC_IO = 2'b10,
    FPC_CYC_WRITE = 2'b11
  } fpc_cyc_e;

  // Debouncer state
  typedef struct packed {
    logic [1:0] sync;
    logic stable;
    logic press;
    logic [31:0] cnt;
  } fpc_deb_s;

endpackage : fpc_pkg

// File: fpc_sync8.sv
// Two-flop synchroniser for the eight data toggle switches
`timescale 1ns/10ps
module fpc_sync8 #(
  parameter int WIDTH = 8
) (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  // State: first and second stage
  typedef struct packed {
    logic [WIDTH-1:0] s1;
    logic [WIDTH-1:0] s2;
  } fpc_sync_s;

  fpc_sync_s st_q;
  fpc_sync_s st_d;

  // Shift through two stages; only stage two is visible
  always_comb begin
    st_d = st_q;
    st_d.s1 = async_in;
    st_d.s2 = st_q.s1;
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign sync_out = st_q.s2;

endmodule : fpc_sync8

// File: fpc_debounce.sv
// Push-button synchroniser and debouncer with a one-cycle press pulse
`timescale 1ns/10ps
module fpc_debounce #(
  parameter int unsigned STABLE_CYC = 1250000
) (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic button,
  output logic press
);

  fpc_pkg::fpc_deb_s st_q;
  fpc_pkg::fpc_deb_s st_d;

  // Accept a new level only after it has held for STABLE_CYC cycles
  always_comb begin
    st_d = st_q;
    st_d.sync = {st_q.sync[0], button};
    st_d.press = 1'b0;
    if (st_q.sync[1] == st_q.stable) begin
      st_d.cnt = '0;
    end else if (st_q.cnt >= STABLE_CYC - 1) begin
      st_d.cnt = '0;
      st_d.stable = st_q.sync[1];
      st_d.press = st_q.sync[1]; // Pulse on the pressed edge only
    end else begin
      st_d.cnt = st_q.cnt + 32'h0000_0001;
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign press = st_q.press;

endmodule : fpc_debounce

// File: fpc_panel.sv
// Front-panel control: buttons, switch jamming, mode sequencing, lamps
// How it works
// - Interrupt press in run lights interrupt lamp and drops run lamp together.
// - Interrupt press while halted lights interrupt lamp at once, stop lamp off.
// - Interrupt press while stepping waits until the current instruction ends.
// - Interrupt press during a jammed instruction keeps interrupt mode afterwards.
// - Each step press in step mode lets the core advance exactly one word.
// - Jammed multi-word entry pauses at each word; operator sets next word.
// - Run press after a jammed instruction resumes full-rate execution from the program counter.
// - Switch byte: leftmost switch is bit 7, rightmost is bit 0.
// - Jammed words replace fetched words; memory stays untouched.
// - Page lamps show the six high bits of the next access.
// - Memory address lamps show the low eight bits of next access.
// - During input/output cycles address lamps show transfer information.
// - Memory contents lamps hold the last word read from memory, not jammed words.
// - Run lamp lit while executing automatically at full rate.
// - Executing a halt instruction outside a jammed instruction stops the machine and lights stop lamp.
// - Stop is left only through an interrupt press; run press is ignored while stopped.
// - Status lamps encode first word, later word, input/output, write.
// - Interrupt is acknowledged at an instruction boundary, or at once while halted.
// - After a jammed instruction the core continues from its counter.
// - Reads from absent memory return all ones, decoded as halt.
`timescale 1ns/10ps
`include "fpc_cfg.svh"
module fpc_panel #(
  parameter int unsigned DEBOUNCE_CYC = `FPC_DEBOUNCE_CYC,
  parameter int PAGE_W = 6,
  parameter int DATA_W = 8
) (
  input wire logic clk_sys,
  input wire logic reset_n,
  // Operator side
  input wire logic btn_interrupt,
  input wire logic btn_step,
  input wire logic btn_run,
  input wire logic [DATA_W-1:0] toggle_switches,
  output logic [PAGE_W-1:0] lamp_page,
  output logic [DATA_W-1:0] memory_address_lamps,
  output logic [DATA_W-1:0] memory_contents_lamps,
  output logic lamp_run,
  output logic lamp_int,
  output logic [1:0] lamp_status,
  output logic lamp_stop,
  // Processor core side
  input wire logic [PAGE_W+DATA_W-1:0] core_addr,
  input wire logic [PAGE_W+DATA_W-1:0] core_io_info,
  input wire logic [1:0] core_cycle_kind,
  input wire logic core_rd_req,
  input wire logic core_instr_done,
  input wire logic core_halt,
  output logic core_go,
  output logic core_jam_active,
  output logic [DATA_W-1:0] core_rd_data,
  output logic core_rd_valid,
  // Memory side
  input wire logic [DATA_W-1:0] mem_rd_data,
  input wire logic mem_present,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    fpc_pkg::fpc_mode_e mode;
    logic int_active;
    logic int_pending;
    logic go;
    logic jam;
    logic [DATA_W-1:0] rd_data;
    logic rd_valid;
    logic [PAGE_W-1:0] page;
    logic [DATA_W-1:0] addr;
    logic [DATA_W-1:0] contents;
    logic run;
    logic lint;
    logic [1:0] status;
    logic stop;
    logic [31:0] ctrl;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } fpc_panel_s;

  fpc_panel_s st_q;
  fpc_panel_s st_d;

  logic int_press;
  logic step_press;
  logic run_press;
  logic [DATA_W-1:0] sw_sync;
  logic btn_en;
  logic [31:0] rd_word;
  logic rd_hit;
  logic [PAGE_W+DATA_W-1:0] shown;
  logic int_take;
  logic step_take;
  logic run_take;

  // ----------------------------------------------------------------
  // Button and switch conditioning
  // ----------------------------------------------------------------
  // One debouncer per push button
  fpc_debounce #(.STABLE_CYC(DEBOUNCE_CYC)) u_deb_int (
    .clk_sys(clk_sys),
    .reset_n(reset_n),
    .button(btn_interrupt),
    .press(int_press)
  );

  fpc_debounce #(.STABLE_CYC(DEBOUNCE_CYC)) u_deb_step (
    .clk_sys(clk_sys),
    .reset_n(reset_n),
    .button(btn_step),
    .press(step_press)
  );

  fpc_debounce #(.STABLE_CYC(DEBOUNCE_CYC)) u_deb_run (
    .clk_sys(clk_sys),
    .reset_n(reset_n),
    .button(btn_run),
    .press(run_press)
  );

  // Switch bank, bit 7 from the leftmost toggle
  fpc_sync8 #(.WIDTH(DATA_W)) u_sw_sync (
    .clk_sys(clk_sys),
    .reset_n(reset_n),
    .async_in(toggle_switches),
    .sync_out(sw_sync)
  );

  assign btn_en = st_q.ctrl[`FPC_CTRL_BTN_EN];

  // ----------------------------------------------------------------
  // Qualified button presses
  // ----------------------------------------------------------------
  // Presses count only while software leaves the buttons enabled;
  // a disabled panel must not even leave a request pending
  assign int_take = int_press & btn_en;
  assign step_take = step_press & btn_en;
  assign run_take = run_press & btn_en;

  // ----------------------------------------------------------------
  // APB read mux
  // ----------------------------------------------------------------
  // Register read data and address hit
  // Unmapped offsets flag an error and read as zero
  always_comb begin
    rd_word = 32'h0000_0000;
    rd_hit = 1'b1;
    case (paddr)
      `FPC_OFS_CTRL: begin
        rd_word = st_q.ctrl;
      end
      `FPC_OFS_STATUS: begin
        rd_word[`FPC_ST_STOP] = st_q.stop;
        rd_word[`FPC_ST_RUN] = st_q.run;
        rd_word[`FPC_ST_INT] = st_q.int_active;
        rd_word[`FPC_ST_PEND] = st_q.int_pending;
        rd_word[`FPC_ST_STEP] = (st_q.mode == fpc_pkg::FPC_MODE_STEP);
      end
      `FPC_OFS_SWITCH: begin
        rd_word[DATA_W-1:0] = sw_sync;
      end
      `FPC_OFS_LAMPS: begin
        rd_word[DATA_W-1:0] = st_q.contents;
        rd_word[15:8] = st_q.addr;
        rd_word[16+PAGE_W-1:16] = st_q.page;
        rd_word[25:24] = st_q.status;
      end
      default: begin
        rd_hit = 1'b0;
      end
    endcase
  end

  // Page and address lamps source: transfer info on I/O cycles
  // The lamps lag the core by one cycle, like every other lamp
  assign shown = (core_cycle_kind == fpc_pkg::FPC_CYC_IO) ?
                 core_io_info : core_addr;

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  // Later blocks override earlier ones: a halt beats a run press and an
  // accepted interrupt beats both, so one mode lamp is lit at a time.
  // Go drops on the accepting edge so the core waits for the jammed word.
  // Pending interrupts survive until a boundary or a stop; a press in the clearing cycle is still taken.
  always_comb begin
    st_d = st_q;

    // APB: answer in the first access cycle, no wait states
    st_d.pready = psel & ~penable;
    if (psel && !penable) begin
      st_d.prdata = pwrite ? 32'h0000_0000 : rd_word;
      st_d.pslverr = ~rd_hit;
    end
    if (psel && penable && st_q.pready && pwrite && rd_hit &&
        paddr == `FPC_OFS_CTRL) begin
      st_d.ctrl = pwdata;
    end

    // Pending interrupt requests are remembered until accepted
    if (int_take) begin
      st_d.int_pending = 1'b1;
    end

    // Permission pulse to the core; level in run mode
    st_d.go = 1'b0;

    case (st_q.mode)
      fpc_pkg::FPC_MODE_RUN: begin
        st_d.go = ~(core_instr_done & (st_q.int_pending | int_take));
      end
      fpc_pkg::FPC_MODE_STEP: begin
        st_d.go = step_take;
      end
      fpc_pkg::FPC_MODE_STOP: begin
        st_d.go = 1'b0;
      end
      default: begin
        st_d.mode = fpc_pkg::FPC_MODE_STOP;
      end
    endcase

    // Run button resumes full-rate execution from the counter
    if (run_take && !st_q.int_active &&
        st_q.mode != fpc_pkg::FPC_MODE_STOP) begin
      st_d.mode = fpc_pkg::FPC_MODE_RUN;
      st_d.go = 1'b1;
    end

    // Halt instruction executed: stopped condition
    // Ignored while jamming, so a jammed word cannot strand the panel
    if (core_halt && !st_q.int_active) begin
      st_d.mode = fpc_pkg::FPC_MODE_STOP;
      st_d.go = 1'b0;
    end

    // Instruction boundary: end jam, then accept interrupt
    if (core_instr_done) begin
      if (st_q.int_active) begin
        // Jammed instruction complete; core resumes from counter
        // Set wins: a press in the completing cycle keeps interrupt mode
        st_d.int_active = st_q.int_pending | int_take;
        st_d.int_pending = 1'b0;
      end else if (st_q.int_pending || int_take) begin
        st_d.int_active = 1'b1;
        st_d.int_pending = 1'b0;
        st_d.mode = fpc_pkg::FPC_MODE_STEP;
        st_d.go = 1'b0;
      end
    end

    // Halted machine takes the interrupt without a boundary
    // No boundary is needed, as nothing executes while stopped
    if (st_q.mode == fpc_pkg::FPC_MODE_STOP &&
        (st_q.int_pending || int_take)) begin
      st_d.int_active = 1'b1;
      st_d.int_pending = 1'b0;
      st_d.mode = fpc_pkg::FPC_MODE_STEP;
    end

    // Word supply: switches when jamming, else memory or halt code
    st_d.jam = st_d.int_active;
    st_d.rd_valid = core_rd_req;
    if (core_rd_req) begin
      if (st_q.int_active) begin
        st_d.rd_data = sw_sync;
      end else if (mem_present) begin
        st_d.rd_data = mem_rd_data;
      end else begin
        st_d.rd_data = `FPC_HALT_CODE;
      end
      // Contents lamps track words read from memory
      if (!st_q.int_active) begin
        st_d.contents = mem_present ? mem_rd_data : `FPC_HALT_CODE;
      end
    end

    // Lamps
    st_d.page = shown[PAGE_W+DATA_W-1:DATA_W];
    st_d.addr = shown[DATA_W-1:0];
    st_d.run = (st_d.mode == fpc_pkg::FPC_MODE_RUN);
    st_d.stop = (st_d.mode == fpc_pkg::FPC_MODE_STOP);
    st_d.lint = st_d.int_active;
    // Left status lamp is bit 1, right status lamp is bit 0
    case (core_cycle_kind)
      fpc_pkg::FPC_CYC_FIRST: st_d.status = 2'h0;
      fpc_pkg::FPC_CYC_LATER: st_d.status = 2'h2;
      fpc_pkg::FPC_CYC_IO: st_d.status = 2'h1;
      fpc_pkg::FPC_CYC_WRITE: st_d.status = 2'h3;
      default: st_d.status = 2'h0;
    endcase
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  // Reset parks the panel stopped, with the buttons enabled
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      st_q <= '0;
      st_q.mode <= fpc_pkg::FPC_MODE_STOP;
      st_q.stop <= 1'b1;
      st_q.ctrl <= `FPC_CTRL_RESET;
    end else begin
      st_q <= st_d;
    end
  end

  // ----------------------------------------------------------------
  // Outputs, all from flip-flops
  // ----------------------------------------------------------------
  // Each pin is a register bit, so no decode glitch reaches a lamp
  assign lamp_page = st_q.page;
  assign memory_address_lamps = st_q.addr;
  assign memory_contents_lamps = st_q.contents;
  assign lamp_run = st_q.run;
  assign lamp_int = st_q.lint;
  assign lamp_status = st_q.status;
  assign lamp_stop = st_q.stop;
  assign core_go = st_q.go;
  assign core_jam_active = st_q.jam;
  assign core_rd_data = st_q.rd_data;
  assign core_rd_valid = st_q.rd_valid;
  assign prdata = st_q.prdata;
  assign pready = st_q.pready;
  assign pslverr = st_q.pslverr;

endmodule : fpc_panel

// File: fpc_panel_assertions.sv
// Concurrent checks on the front-panel control ports
`timescale 1ns/10ps
module fpc_panel_checker (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic [5:0] lamp_page,
  input wire logic [7:0] memory_address_lamps,
  input wire logic lamp_run,
  input wire logic lamp_int,
  input wire logic [1:0] lamp_status,
  input wire logic lamp_stop,
  input wire logic [13:0] core_addr,
  input wire logic [13:0] core_io_info,
  input wire logic [1:0] core_cycle_kind,
  input wire logic core_rd_req,
  input wire logic core_halt,
  input wire logic [7:0] core_rd_data,
  input wire logic core_rd_valid,
  input wire logic mem_present
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!reset_n);
  // Lamp and read-answer relations to core activity
  chk_addr_lamps: assert property (core_cycle_kind != 2'h2 |=>
    {lamp_page, memory_address_lamps} == $past(core_addr))
    else $error("Address lamps miss core address");
  chk_io_lamps: assert property (core_cycle_kind == 2'h2 |=>
    {lamp_page, memory_address_lamps} == $past(core_io_info))
    else $error("Address lamps miss transfer info");
  chk_status_code: assert property (1'b1 |=>
    lamp_status == {$past(core_cycle_kind[0]), $past(core_cycle_kind[1])})
    else $error("Status lamps wrong");
  chk_read_answer: assert property (1'b1 |=>
    core_rd_valid == $past(core_rd_req))
    else $error("Read answer not one cycle later");
  chk_absent_ones: assert property (
    core_rd_req && !mem_present && !lamp_int |=> core_rd_data == 8'hFF)
    else $error("Absent read not all ones");
  chk_run_alone: assert property (lamp_run |-> !lamp_stop && !lamp_int)
    else $error("Run lamp shares with stop or int");
  chk_run_to_int: assert property (
    $fell(lamp_run) && !lamp_stop |-> lamp_int)
    else $error("Run lamp fell without int lamp");
  chk_halt_stops: assert property (core_halt && lamp_run |->
    ##[1:2] lamp_stop) else $error("Halt did not stop");
endmodule : fpc_panel_checker

// File: fpc_operator.sv
// Operator model: pushes buttons and sets the toggle switches
`timescale 1ns/10ps
module fpc_operator (
  input wire logic clk_sys,
  input wire logic [2:0] push,
  input wire logic [7:0] word,
  output logic [2:0] btn,
  output logic [7:0] sw,
  output logic busy
);
  int n = 0;
  assign busy = (n != 0);
  // Hold a button 10 cycles, rest 10; switches move only while idle, never during the rest
  always @(posedge clk_sys) begin
    if (n == 0) begin
      btn <= push;
      sw <= word;
      if (push != 3'h0) n <= 20;
    end else begin
      n <= n - 1;
      if (n == 11) btn <= 3'h0;
    end
  end
endmodule : fpc_operator

// File: tb_top.sv
// Self-checking bench for the front-panel control block
`timescale 1ns/10ps
module tb_top;
  logic clk_sys = 0, reset_n = 0, busy, er;
  logic [2:0] push = 0, btn;
  logic [7:0] word = 0, sw, mc, rd, memory_address_lamps;
  logic [7:0] memory_contents_lamps, core_rd_data, mem_rd_data = 0;
  logic [13:0] core_addr = 0, core_io_info = 0;
  logic [1:0] core_cycle_kind = 0, lamp_status;
  logic core_rd_req = 0, core_instr_done = 0, core_halt = 0;
  logic mem_present = 0, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, rdat;
  logic [5:0] lamp_page;
  logic pready, pslverr, lamp_run, lamp_int, lamp_stop;
  logic core_go, core_jam_active, core_rd_valid;
  int error_cnt = 0, n_compared = 0, gos = 0;
  int m_stop = 1, m_run = 0, m_int = 0;
  initial forever #2 clk_sys = ~clk_sys;
  fpc_panel #(.DEBOUNCE_CYC(4)) uut (.clk_sys, .reset_n,
    .btn_interrupt(btn[0]), .btn_step(btn[1]), .btn_run(btn[2]),
    .toggle_switches(sw), .lamp_page, .memory_address_lamps,
    .memory_contents_lamps, .lamp_run, .lamp_int, .lamp_status,
    .lamp_stop, .core_addr, .core_io_info, .core_cycle_kind,
    .core_rd_req, .core_instr_done, .core_halt, .core_go,
    .core_jam_active, .core_rd_data, .core_rd_valid, .mem_rd_data,
    .mem_present, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr);
  fpc_operator op (.clk_sys, .push, .word, .btn, .sw, .busy);
  // Count step pulses outside run mode
  always @(posedge clk_sys) begin
    if (core_go === 1'b1 && lamp_run === 1'b0) gos <= gos + 1;
  end
  task chk(input string nm, input logic [31:0] seen, input logic [31:0] ex);
    n_compared++;
    if (seen !== ex) begin
      error_cnt++;
      $display("[ERR] %s exp %h seen %h", nm, ex, seen);
    end
  endtask : chk
  task wrap_up;
    $display("Compared %0d, errors %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : wrap_up
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    psel <= 1;
    penable <= 0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1;
    do @(posedge clk_sys); while (pready !== 1'b1);
    rdat = prdata;
    er = pslverr;
    psel <= 0;
    penable <= 0;
  endtask : apb
  task press(input logic [2:0] b);
    @(posedge clk_sys);
    push <= b;
    @(posedge clk_sys);
    push <= 0;
    @(posedge clk_sys); // Let the model take the request before polling
    while (busy) @(posedge clk_sys);
    repeat (4) @(posedge clk_sys);
  endtask : press
  task pulse(input logic h);
    @(posedge clk_sys);
    core_halt <= h;
    core_instr_done <= !h;
    @(posedge clk_sys);
    core_halt <= 0;
    core_instr_done <= 0;
    repeat (3) @(posedge clk_sys);
  endtask : pulse
  task rdw(input logic [7:0] m, input logic p);
    @(posedge clk_sys);
    core_rd_req <= 1;
    mem_rd_data <= m;
    mem_present <= p;
    @(posedge clk_sys);
    core_rd_req <= 0;
    @(posedge clk_sys);
    rd = core_rd_data;
    chk("rd_valid", core_rd_valid, 1);
  endtask : rdw
  task lamps;
    chk("stop", lamp_stop, m_stop[0]);
    chk("run", lamp_run, m_run[0]);
    chk("int", lamp_int, m_int[0]);
    chk("jam_act", core_jam_active, m_int[0]);
  endtask : lamps
  initial begin
    void'($urandom(65385));
    repeat (5) @(posedge clk_sys);
    reset_n <= 1;
    lamps;
    apb(0, 12'h000, 0);
    chk("ctrl", rdat, 1);
    apb(0, 12'h010, 0);
    chk("unmapped", er, 1);
    apb(1, 12'h00C, 0);
    chk("ro_write", er, 0);
    word <= 8'($urandom);
    repeat (30) @(posedge clk_sys);
    apb(0, 12'h008, 0);
    chk("switches", rdat[7:0], word);
    for (int k = 0; k < 4; k++) begin
      core_addr <= 14'($urandom);
      core_io_info <= 14'($urandom);
      core_cycle_kind <= 2'(k);
      repeat (3) @(posedge clk_sys);
      chk("addr", {lamp_page, memory_address_lamps},
          k == 2 ? core_io_info : core_addr);
      chk("status", lamp_status, {k[0], k[1]});
    end
    core_cycle_kind <= 0;
    apb(1, 12'h000, 0);
    press(3'h1);
    lamps;
    apb(1, 12'h000, 1);
    press(3'h1);
    m_stop = 0;
    m_int = 1;
    lamps;
    apb(0, 12'h004, 0);
    chk("status_reg", rdat, 32'h0000_0014);
    rdw(8'h5A, 1);
    chk("jam", rd, word);
    chk("mc_jam", memory_contents_lamps, 0);
    press(3'h2);
    chk("step", gos, 1);
    pulse(0);
    m_int = 0;
    lamps;
    press(3'h4);
    m_run = 1;
    lamps;
    chk("go", core_go, 1);
    mc = 8'($urandom);
    rdw(mc, 1);
    chk("mem", rd, mc);
    chk("mc", memory_contents_lamps, mc);
    apb(0, 12'h00C, 0);
    chk("lamps_reg", rdat, {8'h00, 2'b00, core_addr, mc});
    rdw(8'h00, 0);
    chk("absent", rd, 8'hFF);
    press(3'h1);
    lamps;
    pulse(0);
    m_run = 0;
    m_int = 1;
    lamps;
    press(3'h1);
    pulse(0);
    lamps;
    pulse(0);
    m_int = 0;
    lamps;
    press(3'h1);
    lamps;
    press(3'h2);
    chk("step2", gos, 2);
    pulse(0);
    m_int = 1;
    lamps;
    pulse(0);
    m_int = 0;
    press(3'h4);
    m_run = 1;
    pulse(1);
    m_run = 0;
    m_stop = 1;
    lamps;
    press(3'h4);
    lamps;
    wrap_up;
  end
  // Cut a hang short
  initial begin
    repeat (5000) @(posedge clk_sys);
    error_cnt++;
    wrap_up;
  end
endmodule : tb_top
bind fpc_panel fpc_panel_checker u_chk (.clk_sys, .reset_n, .lamp_page,
  .memory_address_lamps, .lamp_run, .lamp_int, .lamp_status, .lamp_stop,
  .core_addr, .core_io_info, .core_cycle_kind, .core_rd_req, .core_halt,
  .core_rd_data, .core_rd_valid, .mem_present);
